// ---- rtl/fetch_pkg.sv ----
// Shared constants and carrier types for the instruction fetch front end
package fetch_pkg;

    localparam int PADDR_W = 24;
    localparam int WORD_W = 22;
    localparam int PSEL_W = 2;
    localparam int PARCEL_W = 16;
    localparam int NBUF = 4;
    localparam int BUF_SEL_W = 2;
    localparam int BUF_PARCELS = 128;
    localparam int OFS_W = 7;
    localparam int TAG_W = 17;
    localparam int GRP_PARCELS = 32;
    localparam int GRP_OFS_W = 5;
    localparam int GRP_W = 2;
    localparam int GRPS_PER_BUF = 4;
    localparam int MEM_WORDS_PER_CP = 8;
    localparam int MISS_CP = 16;
    localparam logic [1:0] SWITCH_CP = 2'h2;
    localparam logic [PARCEL_W-1:0] ZERO_PARCEL = 16'h0000;

    typedef enum logic [1:0]
    {
        FILL_IDLE = 2'b00,
        FILL_REQ = 2'b01,
        FILL_DATA = 2'b10
    } fill_st_e;

    // Branch target or new program address of an exchange
    typedef struct packed
    {
        logic taken;
        logic [PADDR_W-1:0] target;
    } redirect_s;

    typedef struct packed
    {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [GRP_W-1:0] grp;
    } mem_req_s;

    typedef struct packed
    {
        logic valid;
        logic [GRP_PARCELS-1:0][PARCEL_W-1:0] data;
    } mem_fill_s;

    // Indicators handed to the execution modules on issue
    typedef struct packed
    {
        logic valid;
        logic two;
        logic [PARCEL_W-1:0] first;
        logic [PARCEL_W-1:0] second;
    } issue_s;

endpackage : fetch_pkg

// ---- rtl/fetch_tag_match.sv ----
// Base tag comparator across all instruction buffers
`timescale 1ns/1ns
module fetch_tag_match
(
    input wire logic [fetch_pkg::NBUF-1:0][fetch_pkg::TAG_W-1:0] tags_i,
    input wire logic [fetch_pkg::NBUF-1:0] valid_i,
    input wire logic [fetch_pkg::TAG_W-1:0] tag_i,
    output logic hit_o,
    output logic [fetch_pkg::BUF_SEL_W-1:0] idx_o
);
    import fetch_pkg::*;

    logic [NBUF-1:0] eq;

    genvar g;
    generate
        for (g = 0; g < NBUF; g++)
        begin : g_cmp
            // A voided buffer never matches
            assign eq[g] = valid_i[g] && (tags_i[g] == tag_i);
        end
    endgenerate

    // At most one buffer matches since a block is only fetched on a miss
    always_comb
    begin
        hit_o = |eq;
        idx_o = '0;
        for (int k = 0; k < NBUF; k++)
        begin
            if (eq[k])
            begin
                idx_o = BUF_SEL_W'(k);
            end
        end
    end

endmodule : fetch_tag_match

// ---- rtl/instr_fetch.sv ----
// Instruction fetch front end: program address, parcel registers and buffers
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module instr_fetch
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire fetch_pkg::redirect_s branch_i,
    input wire fetch_pkg::redirect_s exchange_i,
    input wire logic conflict_i,
    input wire logic next_two_i,
    input wire logic mem_busy_i,
    input wire fetch_pkg::mem_fill_s mem_fill_i,
    output fetch_pkg::mem_req_s mem_req_o,
    output logic issue_o,
    output fetch_pkg::issue_s issued_o,
    output logic [fetch_pkg::PADDR_W-1:0] xpkg_p_o,
    output logic [fetch_pkg::PADDR_W-1:0] prog_addr_o
);
    import fetch_pkg::*;

    typedef struct packed
    {
        logic [PADDR_W-1:0] prog_addr;
        logic [PARCEL_W-1:0] next_parcel_reg;
        logic next_v;
        logic [PARCEL_W-1:0] current_parcel_reg;
        logic cur_v;
        logic cur_two;
        logic [PARCEL_W-1:0] lower_parcel_reg;
        logic lower_v;
        logic [BUF_SEL_W-1:0] last_buf;
        logic [1:0] sw_cnt;
        logic [BUF_SEL_W-1:0] rr;
        fill_st_e fst;
        logic [BUF_SEL_W-1:0] fill_buf;
        logic [GRP_W-1:0] fill_grp;
        logic [GRP_W-1:0] fill_n;
        logic [GRPS_PER_BUF-1:0] grp_done;
        logic fill_void;
        logic [NBUF-1:0][TAG_W-1:0] buffer_base_tag;
        logic [NBUF-1:0] bvalid;
        logic [PADDR_W-1:0] xpkg_p;
        issue_s iss;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic [PARCEL_W-1:0] parcel_mem [0:NBUF*BUF_PARCELS-1];

    logic hit;
    logic [BUF_SEL_W-1:0] hit_idx;
    logic [PARCEL_W-1:0] rd_parcel;
    logic issue;
    logic lower_route;
    logic cur_load;
    logic grp_ok;
    logic can_fetch;
    logic fetch_lower;
    logic fetch_next;
    logic fetch_any;
    logic sw_start;
    logic miss_start;
    logic redirect;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer lookup

    fetch_tag_match u_match
    (
        .tags_i(s_r.buffer_base_tag),
        .valid_i(s_r.bvalid),
        .tag_i(s_r.prog_addr[PADDR_W-1:OFS_W]),
        .hit_o(hit),
        .idx_o(hit_idx)
    );

    // Parcel offset is the low 7 bits of the program address
    assign rd_parcel = parcel_mem[{hit_idx, s_r.prog_addr[OFS_W-1:0]}];

    // Refill writes a whole 32-parcel group per cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (s_r.fst == FILL_DATA && mem_fill_i.valid)
        begin
            for (int k = 0; k < GRP_PARCELS; k++)
            begin
                parcel_mem[{s_r.fill_buf, s_r.fill_grp, GRP_OFS_W'(k)}] <= mem_fill_i.data[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parcel movement decisions

    always_comb
    begin
        redirect = branch_i.taken || exchange_i.taken;
        // Two-parcel issue needs its lower parcel present
        issue = s_r.cur_v && !conflict_i && (!s_r.cur_two || s_r.lower_v);
        lower_route = s_r.next_v && next_two_i && !s_r.lower_v;
        cur_load = s_r.next_v && !(next_two_i && !s_r.lower_v) && (!s_r.cur_v || issue);
        // Parcels of a group still in flight are not readable yet
        grp_ok = (s_r.fst == FILL_IDLE) || (s_r.fill_buf != hit_idx)
            || s_r.grp_done[s_r.prog_addr[OFS_W-1:GRP_OFS_W]];
        sw_start = hit && (hit_idx != s_r.last_buf) && (s_r.sw_cnt == 2'h0);
        can_fetch = hit && grp_ok && (s_r.sw_cnt == 2'h0) && !sw_start && !redirect && !rst_i;
        fetch_lower = can_fetch && lower_route;
        // Next register stays empty while a two-parcel instruction waits
        fetch_next = can_fetch && !lower_route && (!s_r.next_v || cur_load)
            && !(s_r.cur_v && s_r.cur_two) && !(cur_load && next_two_i);
        fetch_any = fetch_lower || fetch_next;
        miss_start = !hit && (s_r.fst == FILL_IDLE) && !redirect && !rst_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.iss.valid = 1'b0;

        // Buffer change costs two cycles before the parcel arrives
        if (sw_start)
        begin
            s_nxt.sw_cnt = SWITCH_CP - 2'h1;
            s_nxt.last_buf = hit_idx;
        end
        else if (s_r.sw_cnt != 2'h0)
        begin
            s_nxt.sw_cnt = s_r.sw_cnt - 2'h1;
        end

        // Issue hands the indicators on and frees the current parcel register; a two-parcel issue also frees lower and next
        if (issue)
        begin
            s_nxt.iss.valid = 1'b1;
            s_nxt.iss.two = s_r.cur_two;
            s_nxt.iss.first = s_r.current_parcel_reg;
            s_nxt.iss.second = s_r.lower_parcel_reg;
            s_nxt.cur_v = 1'b0;
            if (s_r.cur_two)
            begin
                s_nxt.lower_v = 1'b0;
                s_nxt.next_parcel_reg = ZERO_PARCEL;
                s_nxt.next_v = 1'b0;
            end
        end

        if (cur_load)
        begin
            s_nxt.current_parcel_reg = s_r.next_parcel_reg;
            s_nxt.cur_v = 1'b1;
            s_nxt.cur_two = next_two_i;
            s_nxt.next_v = 1'b0;
        end

        // Second parcel bypasses the next register
        if (fetch_lower)
        begin
            s_nxt.lower_parcel_reg = rd_parcel;
            s_nxt.lower_v = 1'b1;
        end

        if (fetch_next)
        begin
            s_nxt.next_parcel_reg = rd_parcel;
            s_nxt.next_v = 1'b1;
        end

        // Sequential advance per parcel taken from a buffer
        if (fetch_any)
        begin
            s_nxt.prog_addr = s_r.prog_addr + 24'h1;
        end

        // Refill sequencer; a resident block is never fetched again
        unique case (s_r.fst)
            FILL_IDLE:
            begin
                if (miss_start)
                begin
                    // Round-robin victim choice
                    s_nxt.fst = FILL_REQ;
                    s_nxt.fill_buf = s_r.rr;
                    s_nxt.rr = s_r.rr + 2'h1;
                    // Aligned block base is the upper 17 address bits
                    s_nxt.buffer_base_tag[s_r.rr] = s_r.prog_addr[PADDR_W-1:OFS_W];
                    s_nxt.bvalid[s_r.rr] = 1'b0;
                    s_nxt.fill_grp = s_r.prog_addr[OFS_W-1:GRP_OFS_W];
                    s_nxt.fill_n = '0;
                    s_nxt.grp_done = '0;
                    s_nxt.fill_void = 1'b0;
                end
            end
            FILL_REQ:
            begin
                // Request is held while memory reports busy
                if (!mem_busy_i)
                begin
                    s_nxt.fst = FILL_DATA;
                end
            end
            FILL_DATA:
            begin
                if (mem_fill_i.valid)
                begin
                    s_nxt.grp_done[s_r.fill_grp] = 1'b1;
                    // Wanted group arrives first and opens the buffer
                    if (s_r.fill_n == '0 && !s_r.fill_void)
                    begin
                        s_nxt.bvalid[s_r.fill_buf] = 1'b1;
                    end
                    // Remaining groups wrap around the block
                    s_nxt.fill_grp = s_r.fill_grp + 2'h1;
                    s_nxt.fill_n = s_r.fill_n + 2'h1;
                    if (s_r.fill_n == 2'h3)
                    begin
                        s_nxt.fst = FILL_IDLE;
                    end
                end
            end
            default:
            begin
                s_nxt.fst = FILL_IDLE;
            end
        endcase

        // Taken branch reloads the program address
        if (branch_i.taken)
        begin
            s_nxt.prog_addr = branch_i.target;
            s_nxt.next_v = 1'b0;
            // A waiting two-parcel instruction keeps its second parcel, or it never issues
            s_nxt.lower_v = s_nxt.lower_v && s_nxt.cur_v && s_nxt.cur_two;
        end

        // Exchange saves and reloads the address, voids every buffer
        if (exchange_i.taken)
        begin
            s_nxt.xpkg_p = s_r.prog_addr;
            s_nxt.prog_addr = exchange_i.target;
            s_nxt.next_v = 1'b0;
            s_nxt.lower_v = 1'b0;
            s_nxt.cur_v = 1'b0;
            s_nxt.bvalid = '0;
            s_nxt.fill_void = 1'b1;
        end

        // Master clear resets flags, counters and the saved exchange address; program address and parcel registers keep their
        // contents, so a deadstart must begin with an exchange
        if (rst_i)
        begin
            s_nxt.next_v = 1'b0;
            s_nxt.cur_v = 1'b0;
            s_nxt.cur_two = 1'b0;
            s_nxt.lower_v = 1'b0;
            s_nxt.sw_cnt = '0;
            s_nxt.last_buf = '0;
            s_nxt.rr = '0;
            s_nxt.fst = FILL_IDLE;
            s_nxt.fill_void = 1'b0;
            s_nxt.bvalid = '0;
            s_nxt.grp_done = '0;
            s_nxt.xpkg_p = '0;
            s_nxt.iss = '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb
    begin
        mem_req_o.valid = (s_r.fst == FILL_REQ);
        mem_req_o.tag = s_r.buffer_base_tag[s_r.fill_buf];
        mem_req_o.grp = s_r.fill_grp;
    end

    assign issue_o = issue;
    assign issued_o = s_r.iss;
    assign xpkg_p_o = s_r.xpkg_p;
    assign prog_addr_o = s_r.prog_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_switch;
        sw_start;
    endsequence

    sequence seq_no_fetch2;
        !fetch_any ##1 !fetch_any;
    endsequence
    // An exchange in the same cycle wins over the first group
    sequence seq_first_grp;
        s_r.fst == FILL_DATA && mem_fill_i.valid && s_r.fill_n == 2'h0
            && !s_r.fill_void && !exchange_i.taken;
    endsequence

    chk_p_advance: assert property (fetch_any && !redirect |=>
        s_r.prog_addr == $past(s_r.prog_addr) + 24'h1)
        else $error("program address did not advance by one");

    chk_p_hold: assert property (!fetch_any && !redirect |=>
        $stable(s_r.prog_addr))
        else $error("program address changed without cause");

    chk_xpkg_addr: assert property (exchange_i.taken |=>
        xpkg_p_o === $past(s_r.prog_addr) && s_r.prog_addr == $past(exchange_i.target))
        else $error("exchange address save or reload wrong");

    chk_exch_void: assert property (exchange_i.taken |=> s_r.bvalid == '0 && !hit)
        else $error("buffers still valid after exchange");

    chk_rr_step: assert property (miss_start |=>
        s_r.rr == $past(s_r.rr) + 2'h1 && s_r.fill_buf == $past(s_r.rr))
        else $error("refill counter did not rotate");

    chk_switch_delay: assert property (seq_switch |-> seq_no_fetch2)
        else $error("buffer change delay shorter than two cycles");

    chk_miss_stall: assert property (!hit |-> !fetch_any)
        else $error("fetch without a buffer hit");

    chk_zero_fill: assert property (issue && s_r.cur_two |=>
        s_r.next_parcel_reg == ZERO_PARCEL && !s_r.next_v && !s_r.lower_v)
        else $error("zero parcel not loaded after two-parcel issue");

    chk_fill_valid: assert property (seq_first_grp |=> s_r.bvalid[$past(s_r.fill_buf)])
        else $error("buffer not valid after first group");

    chk_busy_wait: assert property (s_r.fst == FILL_REQ && mem_busy_i |=>
        s_r.fst == FILL_REQ && mem_req_o.valid)
        else $error("refill request dropped while memory busy");

endmodule : instr_fetch

// ---- tb/fill_memory.sv ----
// Central memory model that answers instruction buffer refill requests
`timescale 1ns/1ns
module fill_memory
    import fetch_pkg::*;
#(
    parameter int LAT = 13
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire fetch_pkg::mem_req_s mem_req_i,
    input wire logic hold_busy_i,
    input wire logic [fetch_pkg::PARCEL_W-1:0] salt_i,
    output logic mem_busy_o,
    output fetch_pkg::mem_fill_s mem_fill_o
);
    bit active;
    int wait_cp;
    int sent;
    logic [TAG_W-1:0] tag;
    logic [GRP_W-1:0] grp;
    logic [PADDR_W-1:0] addr;

    assign mem_busy_o = hold_busy_i;

    initial
    begin
        mem_fill_o = '0;
        active = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data lines toggle outside groups so stale parcels are never mistaken for fresh
    always @(posedge sys_clk_i)
    begin
        mem_fill_o.valid <= 1'b0;
        mem_fill_o.data <= ~mem_fill_o.data;
        if (rst_i)
            active = 0;
        else if (!active && mem_req_i.valid === 1'b1 && !mem_busy_o)
        begin
            active = 1;
            wait_cp = LAT;
            sent = 0;
            tag = mem_req_i.tag;
            grp = mem_req_i.grp;
        end
        else if (active)
        begin
            if (wait_cp > 0)
                wait_cp--;
            else
            begin
                // Wanted group first, then the rest in wrapping order
                for (int k = 0; k < GRP_PARCELS; k++)
                begin
                    addr = {tag, grp, k[GRP_OFS_W-1:0]};
                    mem_fill_o.data[k] <= addr[PARCEL_W-1:0] ^ salt_i;
                end
                mem_fill_o.valid <= 1'b1;
                grp = grp + 2'h1;
                sent++;
                if (sent == GRPS_PER_BUF)
                    active = 0;
            end
        end
    end
endmodule : fill_memory

// ---- tb/instruction_fetch_buffers_test.sv ----
// Self-checking bench for the instruction fetch front end
`timescale 1ns/1ns
module instruction_fetch_buffers_test;
    import fetch_pkg::*;

    logic sys_clk_i;
    logic rst_i;
    redirect_s branch_i;
    redirect_s exchange_i;
    logic conflict_i;
    logic next_two_i;
    logic mem_busy_i;
    mem_fill_s mem_fill_i;
    mem_req_s mem_req_o;
    logic issue_o;
    issue_s issued_o;
    logic [PADDR_W-1:0] xpkg_p_o;
    logic [PADDR_W-1:0] prog_addr_o;
    logic hold_busy;
    logic [PARCEL_W-1:0] mem_salt;
    logic [PARCEL_W-1:0] exp_salt;
    logic [31:0] seed;
    logic [PADDR_W-1:0] ptr;
    logic [PADDR_W-1:0] old_ptr;
    logic [PADDR_W-1:0] pa_prev;
    logic [PADDR_W-1:0] pa_hold;
    logic [PADDR_W-1:0] blk [5];
    bit stale;
    bit armed;
    bit redir_d;
    int n_iss;
    int err_count;
    int total_checks;

    instr_fetch uut
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .branch_i(branch_i),
        .exchange_i(exchange_i),
        .conflict_i(conflict_i),
        .next_two_i(next_two_i),
        .mem_busy_i(mem_busy_i),
        .mem_fill_i(mem_fill_i),
        .mem_req_o(mem_req_o),
        .issue_o(issue_o),
        .issued_o(issued_o),
        .xpkg_p_o(xpkg_p_o),
        .prog_addr_o(prog_addr_o)
    );

    fill_memory memory
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .mem_req_i(mem_req_o),
        .hold_busy_i(hold_busy),
        .salt_i(mem_salt),
        .mem_busy_o(mem_busy_i),
        .mem_fill_o(mem_fill_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Parcel held in memory at a program address
    function automatic logic [PARCEL_W-1:0] pval(input logic [PADDR_W-1:0] a);
        return a[PARCEL_W-1:0] ^ exp_salt;
    endfunction : pval

    // Decode of a first-of-two parcel, as the issue logic would see it
    function automatic logic is_two(input logic [PARCEL_W-1:0] p);
        return p[3:0] == 4'hb;
    endfunction : is_two

    // Issue decode reads the next register itself; once a second parcel has gone
    // to the lower register the address no longer points one past it
    assign next_two_i = armed && is_two(uut.s_r.next_parcel_reg);

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    // Issue stream monitor; parcels already issuing when a redirect lands are allowed
    always @(posedge sys_clk_i)
    begin
        logic [PADDR_W-1:0] a;
        logic two;
        if (armed && !rst_i)
        begin
            if (conflict_i)
                check("issue under conflict", issue_o, 24'h0);
            if (!redir_d)
                check("address step", prog_addr_o - pa_prev <= 1, 24'h1);
            if (issued_o.valid === 1'b1)
            begin
                n_iss++;
                a = (stale && issued_o.first !== pval(ptr)) ? old_ptr : ptr;
                if (a == ptr)
                    stale = 0;
                two = is_two(pval(a));
                check("first parcel", issued_o.first, pval(a));
                check("two parcels", issued_o.two, two);
                if (two)
                    check("second parcel", issued_o.second, pval(a + 24'h1));
                if (a == ptr)
                    ptr = a + (two ? 24'h2 : 24'h1);
                else
                    old_ptr = a + (two ? 24'h2 : 24'h1);
            end
        end
        redir_d = branch_i.taken || exchange_i.taken;
        pa_prev = prog_addr_o;
    end

    // Redirect, then run the window and judge whether a refill was requested
    task automatic go(input logic [23:0] t, input bit xchg, input bit miss, input int busy_cp);
        logic [PADDR_W-1:0] p0;
        bit seen_req;
        seen_req = 0;
        p0 = prog_addr_o;
        hold_busy = busy_cp > 0;
        old_ptr = ptr;
        ptr = t;
        stale = 1;
        n_iss = 0;
        if (xchg)
            exchange_i = '{taken: 1'b1, target: t};
        else
            branch_i = '{taken: 1'b1, target: t};
        @(negedge sys_clk_i);
        // Armed only once a known address stands, so no unknown step is judged
        armed = 1;
        exchange_i.taken = 1'b0;
        branch_i.taken = 1'b0;
        check("new address", prog_addr_o, t);
        if (xchg)
            check("outgoing address", xpkg_p_o, p0);
        for (int i = 0; i < 50; i++)
        begin
            conflict_i = rnd() % 4 == 0;
            if (i == busy_cp && busy_cp > 0)
            begin
                check("request held while busy", mem_req_o.valid, 24'h1);
                hold_busy = 1'b0;
            end
            if (mem_req_o.valid === 1'b1 && !seen_req)
            begin
                seen_req = 1;
                check("refill tag", mem_req_o.tag, t[23:7]);
                check("first group", mem_req_o.grp, t[6:5]);
            end
            @(negedge sys_clk_i);
        end
        conflict_i = 1'b0;
        check("refill requested", seen_req, miss);
        check("instructions issued", n_iss > 0, 24'h1);
    endtask : go

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever
            #25 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        seed = 32'h0000004e;
        rst_i = 1'b1;
        branch_i = '0;
        exchange_i = '0;
        conflict_i = 1'b0;
        hold_busy = 1'b0;
        mem_salt = 16'h3c69;
        exp_salt = 16'h3c69;
        err_count = 0;
        total_checks = 0;
        armed = 0;
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        check("outgoing address after clear", xpkg_p_o, 24'h0);
        check("no issue after clear", issue_o, 24'h0);
        check("no refill after clear", mem_req_o.valid, 24'h0);
        // Distinct block tags, entry points kept well inside each block
        for (int i = 0; i < 5; i++)
        begin
            blk[i] = {17'(rnd() & 32'h1fff8 | i), 7'h00};
            blk[i][5:0] = 6'(rnd() % 48);
        end
        go(blk[0], 1, 1, 0);
        go(blk[1], 0, 1, 6);
        go(blk[2], 0, 1, 0);
        go(blk[3], 0, 1, 0);
        // Memory changes under a resident block must not be seen
        mem_salt = 16'h5a5a;
        go(blk[0] + 24'h5, 0, 0, 0);
        mem_salt = exp_salt;
        go(blk[4], 0, 1, 0);
        go(blk[1], 0, 0, 0);
        go(blk[0], 0, 1, 0);
        // Master clear in mid-run: address kept, fetch and issue blocked
        pa_hold = prog_addr_o;
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check("address kept by clear", prog_addr_o, pa_hold);
        check("no issue in clear", issue_o, 24'h0);
        check("no refill in clear", mem_req_o.valid, 24'h0);
        rst_i = 1'b0;
        go(blk[0], 1, 1, 0);
        wrap_up();
    end
endmodule : instruction_fetch_buffers_test
